// File: include/phlc_pkg.sv
// Constants, register map and types shared by the PLL holdover and lock control block.
package phlc_pkg;

    localparam int unsigned ADDR_W = 10;
    localparam int unsigned DATA_W = 8;
    localparam int unsigned NUM_CHANNELS = 4;
    localparam int unsigned NUM_OUTPUTS = 16;
    localparam int unsigned LOCK_COUNT_W = 8;

    // Register offsets.
    localparam logic [ADDR_W-1:0] ADDR_STATUS_PIN = 10'h017;
    localparam logic [ADDR_W-1:0] ADDR_LOCK_DETECT = 10'h018;
    localparam logic [ADDR_W-1:0] ADDR_LOCK_PIN = 10'h01a;
    localparam logic [ADDR_W-1:0] ADDR_REFERENCE_MONITOR_PIN_PIN = 10'h01b;
    localparam logic [ADDR_W-1:0] ADDR_REF_SELECT = 10'h01c;
    localparam logic [ADDR_W-1:0] ADDR_HOLDOVER = 10'h01d;
    localparam logic [ADDR_W-1:0] ADDR_GATING_LOW = 10'h0fc;
    localparam logic [ADDR_W-1:0] ADDR_GATING_HIGH = 10'h0fd;
    localparam logic [ADDR_W-1:0] ADDR_CHAN0_DIV = 10'h191;
    localparam logic [ADDR_W-1:0] ADDR_CHAN1_DIV = 10'h194;
    localparam logic [ADDR_W-1:0] ADDR_CHAN2_DIV = 10'h197;
    localparam logic [ADDR_W-1:0] ADDR_CHAN3_DIV = 10'h19a;

    localparam logic [DATA_W-1:0] REG_RESET = 8'h00;
    localparam logic [DATA_W-1:0] READ_UNMAPPED = 8'h00;

    // Field positions.
    localparam int unsigned STATUS_SEL_MSB = 7;
    localparam int unsigned STATUS_SEL_LSB = 2;
    localparam int unsigned REFERENCE_MONITOR_PIN_SEL_MSB = 4;
    localparam int unsigned LOCK_CNT_MSB = 6;
    localparam int unsigned LOCK_CNT_LSB = 5;
    localparam int unsigned LOCK_WINDOW_BIT = 4;
    localparam int unsigned LOCK_DISABLE_BIT = 3;
    localparam int unsigned LOCK_PIN_SEL_MSB = 5;
    localparam int unsigned REF_AUTO_SWITCH_BIT = 4;
    localparam int unsigned REF_PREFER_BIT = 3;
    localparam int unsigned REF_BUF_MSB = 2;
    localparam int unsigned REF_BUF_LSB = 1;
    localparam int unsigned HOLD_COMP_EN_BIT = 3;
    localparam int unsigned HOLD_MANUAL_BIT = 1;
    localparam int unsigned HOLD_EN_BIT = 0;
    localparam int unsigned IGNORE_SYNC_BIT = 6;

    // Lock pin drive codes.
    localparam logic [5:0] LOCK_PIN_CHARGED = 6'h04;
    localparam logic [5:0] LOCK_PIN_DIGITAL = 6'h01;

    // Source codes for the status and reference monitor pin selectors.
    localparam logic [5:0] SEL_DIGITAL_LOCK = 6'h01;
    localparam logic [5:0] SEL_LOCK_COMPARATOR = 6'h02;

    // Consecutive in-window cycles needed for lock, by counter field code.
    localparam logic [LOCK_COUNT_W-1:0] LOCK_CYCLES_CODE0 = 8'h05;
    localparam logic [LOCK_COUNT_W-1:0] LOCK_CYCLES_CODE1 = 8'h10;
    localparam logic [LOCK_COUNT_W-1:0] LOCK_CYCLES_CODE2 = 8'h40;
    localparam logic [LOCK_COUNT_W-1:0] LOCK_CYCLES_CODE3 = 8'hff;

    typedef enum logic [1:0] {
        HO_ARMED,
        HO_SYNC_LOW,
        HO_WAIT_REF,
        HO_REACQUIRE
    } phlc_hold_state_t;

endpackage

// File: tb/phlc_pll_model.sv
// Behavioural PLL datapath and lock pin capacitor facing the lock control block.
`timescale 1ns/1ns
module phlc_pll_model #(parameter int CHARGE_CYCLES = 20) (
    input wire logic clk,
    input wire logic refOn,
    input wire logic inLock,
    input wire logic lockPinSourceEn,
    input wire logic lockPinShortEn,
    output logic pfdCycle = 1'b0,
    output logic pfdInLockWindow = 1'b0,
    output logic pfdOverUnlock = 1'b0,
    output logic pfdRefEdge = 1'b0,
    output logic lockPinComparator = 1'b0
);
    int phase = 0;
    int charge = 0;
    // Without a reference the detector still reports cycles and its inLock-driven error flags but never a reference edge.
    always @(negedge clk) begin
        phase <= (phase + 1) % 4;
        pfdCycle <= (phase == 0);
        pfdRefEdge <= (phase == 0) && refOn;
        pfdInLockWindow <= inLock;
        pfdOverUnlock <= !inLock;
        // The capacitor charges slowly, but a short empties it at once.
        if (lockPinShortEn === 1'b1) begin
            charge <= 0;
        end else if (lockPinSourceEn === 1'b1 && charge < CHARGE_CYCLES) begin
            charge <= charge + 1;
        end
        lockPinComparator <= (charge >= CHARGE_CYCLES);
    end
endmodule

// File: tb/test_pll_holdover_lock_control.sv
// Self-checking bench for the PLL holdover and lock control block.
`timescale 1ns/1ns
module test_pll_holdover_lock_control;
    import phlc_pkg::*;
    logic clk = 0, rst_n = 0, regWrEn = 0, regRdEn = 0, syncPin_n = 1, refOn = 0, inLock = 0;
    logic [ADDR_W-1:0] regAddr = '0;
    logic [DATA_W-1:0] regWrData = '0, regRdData;
    logic regRdValid, pfdCycle, pfdInLockWindow, pfdOverUnlock, pfdRefEdge, lockPinComparator;
    logic lockPinSourceEn, lockPinShortEn, lockPinOut, lockPinOutEn, statusPinOut, chargePumpHiZ;
    logic referenceMonitorPinOut, bCounterReset, lockWindowHighRange, autoSwitchEnable;
    logic preferSecondReference, digitalLockFlag;
    logic [1:0] refBufferEnable;
    logic [NUM_OUTPUTS-1:0] clkOutEnable;
    logic [NUM_CHANNELS-1:0] channelSyncStop;
    logic [DATA_W-1:0] expQ[$];
    logic [ADDR_W-1:0] regMap[12] = '{ADDR_STATUS_PIN, ADDR_LOCK_DETECT, ADDR_LOCK_PIN, ADDR_REFERENCE_MONITOR_PIN_PIN,
        ADDR_REF_SELECT, ADDR_HOLDOVER, ADDR_GATING_LOW, ADDR_GATING_HIGH, ADDR_CHAN0_DIV, ADDR_CHAN1_DIV,
        ADDR_CHAN2_DIV, ADDR_CHAN3_DIV};
    int err_total = 0, check_count = 0, cycles = 0, seed = 32'h9562;

    phlc_holdover_lock_control dut (.clk, .rst_n, .regAddr, .regWrEn, .regWrData, .regRdEn, .regRdData,
        .regRdValid, .pfdCycle, .pfdInLockWindow, .pfdOverUnlock, .pfdRefEdge, .lockPinComparator,
        .syncPin_n, .lockPinSourceEn, .lockPinShortEn, .lockPinOut, .lockPinOutEn, .statusPinOut,
        .referenceMonitorPinOut, .chargePumpHiZ, .bCounterReset, .clkOutEnable, .channelSyncStop,
        .lockWindowHighRange, .autoSwitchEnable, .preferSecondReference, .refBufferEnable, .digitalLockFlag);
    phlc_pll_model model (.clk, .refOn, .inLock, .lockPinSourceEn, .lockPinShortEn, .pfdCycle,
        .pfdInLockWindow, .pfdOverUnlock, .pfdRefEdge, .lockPinComparator);

    initial forever #50 clk = ~clk;

    task automatic finish_test();
        $display("checks %0d mismatches %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        check_count++;
        if (got !== exp) begin
            err_total++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // Each access leaves one idle cycle so a strobe is never lowered and raised in one step.
    task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        regAddr = a;
        regWrData = d;
        regWrEn = 1;
        @(negedge clk) regWrEn = 0;
        @(negedge clk);
    endtask

    task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
        regAddr = a;
        regRdEn = 1;
        expQ.push_back(e);
        @(negedge clk) regRdEn = 0;
        @(negedge clk);
    endtask

    task automatic pfdWait(input int k);
        while (k > 0) begin
            @(negedge clk);
            if (pfdCycle === 1'b1 && pfdInLockWindow === 1'b1) k--;
        end
    endtask

    // The reset pulse follows detector signals that move on the falling edge, so it is read at the rising edge.
    task automatic waitExit();
        int n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (bCounterReset !== 1'b1 && n < 40);
        chk(bCounterReset, 1);
        chk(chargePumpHiZ, 1);
        @(negedge clk);
        chk(chargePumpHiZ, 0);
    endtask

    always @(negedge clk) begin
        cycles++;
        if (cycles > 3000) begin
            err_total++;
            finish_test();
        end
        if (regRdValid === 1'b1) chk(regRdData, expQ.pop_front());
    end

    initial begin
        logic [DATA_W-1:0] d;
        repeat (4) @(negedge clk);
        rst_n = 1;
        for (int i = 0; i < 12; i++) rd(regMap[i], REG_RESET);
        chk(lockWindowHighRange, 1);
        for (int i = 0; i < 12; i++) begin
            d = DATA_W'($random(seed));
            wr(regMap[i], d);
            rd(regMap[i], d);
        end
        wr(10'h100, 8'hff);
        rd(10'h100, READ_UNMAPPED);
        $display("register test done");
        wr(ADDR_LOCK_DETECT, 8'h00);
        wr(ADDR_LOCK_PIN, {2'h0, LOCK_PIN_CHARGED});
        wr(ADDR_STATUS_PIN, {SEL_LOCK_COMPARATOR, 2'h0});
        wr(ADDR_REFERENCE_MONITOR_PIN_PIN, {2'h0, SEL_LOCK_COMPARATOR});
        wr(ADDR_REF_SELECT, 8'h16);
        wr(ADDR_GATING_LOW, 8'hff);
        wr(ADDR_GATING_HIGH, 8'h00);
        for (int i = 8; i < 12; i++) wr(regMap[i], (i == 8) ? 8'h40 : 8'h00);
        wr(ADDR_HOLDOVER, 8'h09);
        chk({autoSwitchEnable, preferSecondReference, refBufferEnable}, 4'hb);
        inLock <= 1;
        refOn <= 1;
        pfdWait(4);
        chk(digitalLockFlag, 0);
        pfdWait(1);
        chk(digitalLockFlag, 1);
        chk({lockPinSourceEn, lockPinShortEn}, 2'h2);
        repeat (40) @(negedge clk);
        chk({statusPinOut, referenceMonitorPinOut}, 2'h3);
        chk(clkOutEnable, 16'hffff);
        inLock <= 0;
        refOn <= 0;
        repeat (6) @(negedge clk);
        chk({digitalLockFlag, lockPinShortEn}, 2'h1);
        repeat (8) @(negedge clk);
        chk(chargePumpHiZ, 1);
        chk(clkOutEnable, 16'hff00);
        repeat (40) @(negedge clk);
        chk(chargePumpHiZ, 1);
        refOn <= 1;
        waitExit();
        repeat (20) @(negedge clk);
        chk(chargePumpHiZ, 0);
        $display("automatic holdover test done");
        wr(ADDR_HOLDOVER, 8'h0b);
        refOn <= 0;
        syncPin_n = 0;
        repeat (6) @(negedge clk);
        chk(chargePumpHiZ, 1);
        chk(channelSyncStop, 4'he);
        syncPin_n = 1;
        repeat (8) @(negedge clk);
        chk(chargePumpHiZ, 1);
        refOn <= 1;
        waitExit();
        wr(ADDR_HOLDOVER, 8'h0a);
        syncPin_n = 0;
        repeat (8) @(negedge clk);
        chk(chargePumpHiZ, 0);
        syncPin_n = 1;
        $display("manual holdover test done");
        wr(ADDR_HOLDOVER, 8'h01);
        inLock <= 1;
        repeat (40) @(negedge clk);
        chk(clkOutEnable, 16'hff00);
        wr(ADDR_STATUS_PIN, {SEL_DIGITAL_LOCK, 2'h0});
        wr(ADDR_LOCK_PIN, {2'h0, LOCK_PIN_DIGITAL});
        chk({statusPinOut, lockPinOutEn, lockPinOut, lockPinSourceEn, lockPinShortEn}, 5'h1c);
        inLock <= 0;
        refOn <= 0;
        repeat (20) @(negedge clk);
        chk(chargePumpHiZ, 0);
        wr(ADDR_LOCK_DETECT, 8'h18);
        inLock <= 1;
        repeat (30) @(negedge clk);
        chk({digitalLockFlag, lockWindowHighRange}, 2'h0);
        $display("comparator and disable test done");
        finish_test();
    end
endmodule

// File: verilog/phlc_holdover_lock_control.sv
// PLL lock indication, charged lock pin control and holdover controller.
// Notes on behaviour
// - Charged mode: source current while locked, else ground.
// - One unlocked cycle discharges the lock pin.
// - Comparator selectable on monitor and status pins.
// - Gated outputs enabled only while charged indicator high.
// - Holdover makes charge pump high impedance.
// - Master enable gates manual and automatic holdover.
// - Sync falling edge enters manual holdover immediately.
// - Mode bit: set manual, clear automatic.
// - Exit only on next reference phase detector edge or on master enable clear.
// - Exit event resets B counter, not prescaler.
// - Channel without ignore bit stops on sync low.
// - Automatic holdover enters on sensed loss of lock.
// - Comparator disabled means lock pin sensed high.
// - Automatic holdover holds while no reference edges.
// - Rearm only after relock and lock pin high.
// - Holdover follows selected reference, ends at edge.
// - Counter field sets cycles to lock; 00 is five.
// - Disable bit turns digital lock circuit off.
// - Window bit zero selects high range window.
// - Reference control: auto switch, preference, buffer enables.
// - Lock after count in window; drop on one overshoot.
`timescale 1ns/1ns
module phlc_holdover_lock_control (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [phlc_pkg::ADDR_W-1:0] regAddr,
    input wire logic regWrEn,
    input wire logic [phlc_pkg::DATA_W-1:0] regWrData,
    input wire logic regRdEn,
    output logic [phlc_pkg::DATA_W-1:0] regRdData,
    output logic regRdValid,
    input wire logic pfdCycle,
    input wire logic pfdInLockWindow,
    input wire logic pfdOverUnlock,
    input wire logic pfdRefEdge,
    input wire logic lockPinComparator,
    input wire logic syncPin_n,
    output logic lockPinSourceEn,
    output logic lockPinShortEn,
    output logic lockPinOut,
    output logic lockPinOutEn,
    output logic statusPinOut,
    output logic referenceMonitorPinOut,
    output logic chargePumpHiZ,
    output logic bCounterReset,
    output logic [phlc_pkg::NUM_OUTPUTS-1:0] clkOutEnable,
    output logic [phlc_pkg::NUM_CHANNELS-1:0] channelSyncStop,
    output logic lockWindowHighRange,
    output logic autoSwitchEnable,
    output logic preferSecondReference,
    output logic [1:0] refBufferEnable,
    output logic digitalLockFlag
);
    import phlc_pkg::*;

    logic [DATA_W-1:0] statusPinCtrl_reg;
    logic [DATA_W-1:0] lockDetectCtrl_reg;
    logic [DATA_W-1:0] lockPinCtrl_reg;
    logic [DATA_W-1:0] refmonPinCtrl_reg;
    logic [DATA_W-1:0] refSelectCtrl_reg;
    logic [DATA_W-1:0] holdoverCtrl_reg;
    logic [DATA_W-1:0] gatingLow_reg;
    logic [DATA_W-1:0] gatingHigh_reg;
    logic [DATA_W-1:0] chanDiv_reg [NUM_CHANNELS];
    logic [LOCK_COUNT_W-1:0] lockCount_reg;
    logic lockFlag_reg;
    logic lockSync1_reg;
    logic lockSync2_reg;
    logic lockSync3_reg;
    logic lockPinLevel_reg;
    logic syncSync1_reg;
    logic syncSync2_reg;
    logic syncSync3_reg;
    logic syncLevel_reg;
    logic syncPrev_reg;
    phlc_hold_state_t hoState_reg;
    phlc_hold_state_t hoState_next;
    logic holdEnable;
    logic manualMode;
    logic compEnable;
    logic lockDisable;
    logic chargedMode;
    logic lockSensed;
    logic chargedLockIndicator;
    logic syncFall;
    logic manualTrigger;
    logic autoTrigger;
    logic [NUM_OUTPUTS-1:0] gateBits;

    function automatic logic [LOCK_COUNT_W-1:0] lockCycles(input logic [1:0] code);
        logic [LOCK_COUNT_W-1:0] cycles;
        unique case (code)
            2'b00: cycles = LOCK_CYCLES_CODE0;
            2'b01: cycles = LOCK_CYCLES_CODE1;
            2'b10: cycles = LOCK_CYCLES_CODE2;
            2'b11: cycles = LOCK_CYCLES_CODE3;
        endcase
        return cycles;
    endfunction

    // Both pin selectors share the same source codes.
    function automatic logic pinSource(input logic [5:0] sel, input logic lockFlag, input logic comparator);
        logic value;
        value = 1'b0;
        if (sel == SEL_DIGITAL_LOCK) begin
            value = lockFlag;
        end else if (sel == SEL_LOCK_COMPARATOR) begin
            value = comparator;
        end
        return value;
    endfunction

    // Register writes.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            statusPinCtrl_reg <= REG_RESET;
            lockDetectCtrl_reg <= REG_RESET;
            lockPinCtrl_reg <= REG_RESET;
            refmonPinCtrl_reg <= REG_RESET;
            refSelectCtrl_reg <= REG_RESET;
            holdoverCtrl_reg <= REG_RESET;
            gatingLow_reg <= REG_RESET;
            gatingHigh_reg <= REG_RESET;
            for (int i = 0; i < NUM_CHANNELS; i++) begin
                chanDiv_reg[i] <= REG_RESET;
            end
        end else if (regWrEn) begin
            case (regAddr)
                ADDR_STATUS_PIN: statusPinCtrl_reg <= regWrData;
                ADDR_LOCK_DETECT: lockDetectCtrl_reg <= regWrData;
                ADDR_LOCK_PIN: lockPinCtrl_reg <= regWrData;
                ADDR_REFERENCE_MONITOR_PIN_PIN: refmonPinCtrl_reg <= regWrData;
                ADDR_REF_SELECT: refSelectCtrl_reg <= regWrData;
                ADDR_HOLDOVER: holdoverCtrl_reg <= regWrData;
                ADDR_GATING_LOW: gatingLow_reg <= regWrData;
                ADDR_GATING_HIGH: gatingHigh_reg <= regWrData;
                ADDR_CHAN0_DIV: chanDiv_reg[0] <= regWrData;
                ADDR_CHAN1_DIV: chanDiv_reg[1] <= regWrData;
                ADDR_CHAN2_DIV: chanDiv_reg[2] <= regWrData;
                ADDR_CHAN3_DIV: chanDiv_reg[3] <= regWrData;
                default: ;
            endcase
        end
    end

    // Register reads answer one cycle after the strobe.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            regRdData <= READ_UNMAPPED;
            regRdValid <= 1'b0;
        end else begin
            regRdValid <= regRdEn;
            if (regRdEn) begin
                case (regAddr)
                    ADDR_STATUS_PIN: regRdData <= statusPinCtrl_reg;
                    ADDR_LOCK_DETECT: regRdData <= lockDetectCtrl_reg;
                    ADDR_LOCK_PIN: regRdData <= lockPinCtrl_reg;
                    ADDR_REFERENCE_MONITOR_PIN_PIN: regRdData <= refmonPinCtrl_reg;
                    ADDR_REF_SELECT: regRdData <= refSelectCtrl_reg;
                    ADDR_HOLDOVER: regRdData <= holdoverCtrl_reg;
                    ADDR_GATING_LOW: regRdData <= gatingLow_reg;
                    ADDR_GATING_HIGH: regRdData <= gatingHigh_reg;
                    ADDR_CHAN0_DIV: regRdData <= chanDiv_reg[0];
                    ADDR_CHAN1_DIV: regRdData <= chanDiv_reg[1];
                    ADDR_CHAN2_DIV: regRdData <= chanDiv_reg[2];
                    ADDR_CHAN3_DIV: regRdData <= chanDiv_reg[3];
                    default: regRdData <= READ_UNMAPPED;
                endcase
            end
        end
    end

    assign holdEnable = holdoverCtrl_reg[HOLD_EN_BIT];
    assign manualMode = holdoverCtrl_reg[HOLD_MANUAL_BIT];
    assign compEnable = holdoverCtrl_reg[HOLD_COMP_EN_BIT];
    assign lockDisable = lockDetectCtrl_reg[LOCK_DISABLE_BIT];
    assign chargedMode = lockPinCtrl_reg[LOCK_PIN_SEL_MSB:0] == LOCK_PIN_CHARGED;
    assign lockWindowHighRange = !lockDetectCtrl_reg[LOCK_WINDOW_BIT];
    assign autoSwitchEnable = refSelectCtrl_reg[REF_AUTO_SWITCH_BIT];
    assign preferSecondReference = refSelectCtrl_reg[REF_PREFER_BIT];
    assign refBufferEnable = refSelectCtrl_reg[REF_BUF_MSB:REF_BUF_LSB];
    assign digitalLockFlag = lockFlag_reg;

    // Pin synchronisers: a new level is accepted once the last two stages agree.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            lockSync1_reg <= 1'b0;
            lockSync2_reg <= 1'b0;
            lockSync3_reg <= 1'b0;
            lockPinLevel_reg <= 1'b0;
            syncSync1_reg <= 1'b1;
            syncSync2_reg <= 1'b1;
            syncSync3_reg <= 1'b1;
            syncLevel_reg <= 1'b1;
            syncPrev_reg <= 1'b1;
        end else begin
            lockSync1_reg <= lockPinComparator;
            lockSync2_reg <= lockSync1_reg;
            lockSync3_reg <= lockSync2_reg;
            if (lockSync2_reg == lockSync3_reg) begin
                lockPinLevel_reg <= lockSync3_reg;
            end
            syncSync1_reg <= syncPin_n;
            syncSync2_reg <= syncSync1_reg;
            syncSync3_reg <= syncSync2_reg;
            if (syncSync2_reg == syncSync3_reg) begin
                syncLevel_reg <= syncSync3_reg;
            end
            syncPrev_reg <= syncLevel_reg;
        end
    end

    assign lockSensed = compEnable ? lockPinLevel_reg : 1'b1;
    assign chargedLockIndicator = compEnable & lockPinLevel_reg;
    assign syncFall = syncPrev_reg & !syncLevel_reg;
    // Digital lock detect. The phase comparison itself lives in the datapath.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            lockCount_reg <= '0;
            lockFlag_reg <= 1'b0;
        end else if (lockDisable) begin
            lockCount_reg <= '0;
            lockFlag_reg <= 1'b0;
        end else if (pfdCycle) begin
            if (pfdOverUnlock) begin
                lockCount_reg <= '0;
                lockFlag_reg <= 1'b0;
            end else if (pfdInLockWindow) begin
                if (lockCount_reg + 1'b1 >= lockCycles(lockDetectCtrl_reg[LOCK_CNT_MSB:LOCK_CNT_LSB])) begin
                    lockFlag_reg <= 1'b1;
                end else begin
                    lockCount_reg <= lockCount_reg + 1'b1;
                end
            end else begin
                // Outside the lock window but inside the unlock threshold: no new lock, no loss.
                lockCount_reg <= '0;
            end
        end
    end

    // Charged mode: the capacitor on the lock pin only charges while locked.
    always_comb begin
        lockPinSourceEn = chargedMode & lockFlag_reg;
        lockPinShortEn = chargedMode & !lockFlag_reg;
        lockPinOut = lockFlag_reg;
        lockPinOutEn = lockPinCtrl_reg[LOCK_PIN_SEL_MSB:0] == LOCK_PIN_DIGITAL;
    end
    assign manualTrigger = holdEnable & manualMode & syncFall;
    assign autoTrigger = holdEnable & !manualMode & !lockSensed;

    // Holdover state machine. Entry is combinational on the trigger; leaving is only taken on a
    // reference phase detector edge or when the master enable is cleared, so a stray sync release cannot pump.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            hoState_reg <= HO_ARMED;
        end else begin
            hoState_reg <= hoState_next;
        end
    end

    always_comb begin
        hoState_next = hoState_reg;
        unique case (hoState_reg)
            HO_ARMED: begin
                if (manualTrigger) begin
                    hoState_next = HO_SYNC_LOW;
                end else if (autoTrigger) begin
                    hoState_next = HO_WAIT_REF;
                end
            end
            HO_SYNC_LOW: begin
                if (syncLevel_reg) begin
                    hoState_next = HO_WAIT_REF;
                end
            end
            HO_WAIT_REF: begin
                if (pfdRefEdge) begin
                    hoState_next = manualMode ? HO_ARMED : HO_REACQUIRE;
                end else if (manualTrigger) begin
                    hoState_next = HO_SYNC_LOW;
                end
            end
            HO_REACQUIRE: begin
                if (manualTrigger) begin
                    hoState_next = HO_SYNC_LOW;
                end else if (lockFlag_reg && lockSensed) begin
                    hoState_next = HO_ARMED;
                end
            end
        endcase
        if (!holdEnable) begin
            hoState_next = HO_ARMED;
        end
    end

    // High impedance, never a forced pump up or down, while holding.
    always_comb begin
        chargePumpHiZ = 1'b0;
        if (holdEnable) begin
            unique case (hoState_reg)
                HO_ARMED: chargePumpHiZ = manualTrigger | autoTrigger;
                HO_SYNC_LOW: chargePumpHiZ = 1'b1;
                HO_WAIT_REF: chargePumpHiZ = 1'b1;
                HO_REACQUIRE: chargePumpHiZ = manualTrigger;
            endcase
        end
    end

    // The prescaler is left running; only the B counter is realigned.
    assign bCounterReset = holdEnable & (hoState_reg == HO_WAIT_REF) & pfdRefEdge;
    assign gateBits = {gatingHigh_reg, gatingLow_reg};
    // Registered pin outputs.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            statusPinOut <= 1'b0;
            referenceMonitorPinOut <= 1'b0;
            clkOutEnable <= '0;
            channelSyncStop <= '0;
        end else begin
            statusPinOut <= pinSource(statusPinCtrl_reg[STATUS_SEL_MSB:STATUS_SEL_LSB], lockFlag_reg,
                lockPinLevel_reg);
            referenceMonitorPinOut <= pinSource({1'b0, refmonPinCtrl_reg[REFERENCE_MONITOR_PIN_SEL_MSB:0]}, lockFlag_reg,
                lockPinLevel_reg);
            for (int i = 0; i < NUM_OUTPUTS; i++) begin
                clkOutEnable[i] <= !gateBits[i] | chargedLockIndicator;
            end
            for (int c = 0; c < NUM_CHANNELS; c++) begin
                channelSyncStop[c] <= !chanDiv_reg[c][IGNORE_SYNC_BIT] & !syncLevel_reg;
            end
        end
    end

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    property p_charged_source;
        chargedMode && lockFlag_reg |-> lockPinSourceEn && !lockPinShortEn;
    endproperty
    a_charged_source: assert property (p_charged_source) else $error("Lock pin not sourcing while locked.");
    property p_drop_discharge;
        chargedMode && pfdCycle && pfdOverUnlock && !lockDisable |=> lockPinShortEn && !lockPinSourceEn;
    endproperty
    a_drop_discharge: assert property (p_drop_discharge) else $error("Lock pin not discharged on unlock.");
    property p_gate_output;
        gatingLow_reg[0] && !chargedLockIndicator |=> !clkOutEnable[0];
    endproperty
    a_gate_output: assert property (p_gate_output) else $error("Gated output enabled without lock.");
    property p_master_enable;
        !holdEnable |-> !chargePumpHiZ && !bCounterReset;
    endproperty
    a_master_enable: assert property (p_master_enable) else $error("Holdover acted while disabled.");
    sequence s_sync_fall;
        holdEnable && manualMode && syncPrev_reg && !syncLevel_reg;
    endsequence
    property p_manual_entry;
        s_sync_fall |-> chargePumpHiZ ##1 (hoState_reg == HO_SYNC_LOW || !holdEnable);
    endproperty
    a_manual_entry: assert property (p_manual_entry) else $error("Sync fall did not enter holdover.");
    property p_hold_without_ref;
        hoState_reg == HO_WAIT_REF && !pfdRefEdge && holdEnable |=> chargePumpHiZ || !holdEnable;
    endproperty
    a_hold_without_ref: assert property (p_hold_without_ref) else $error("Left holdover without edge.");
    sequence s_ref_exit;
        hoState_reg == HO_WAIT_REF && pfdRefEdge && holdEnable;
    endsequence
    property p_exit_resets_b;
        s_ref_exit |-> bCounterReset ##1 hoState_reg != HO_WAIT_REF;
    endproperty
    a_exit_resets_b: assert property (p_exit_resets_b) else $error("B counter not reset on exit.");
    property p_auto_entry;
        hoState_reg == HO_ARMED && holdEnable && !manualMode && !lockSensed |-> chargePumpHiZ;
    endproperty
    a_auto_entry: assert property (p_auto_entry) else $error("Loss of lock did not enter holdover.");
    property p_comp_off;
        !compEnable |-> lockSensed;
    endproperty
    a_comp_off: assert property (p_comp_off) else $error("Lock pin not sensed high.");
    property p_no_rearm;
        hoState_reg == HO_REACQUIRE && !(lockFlag_reg && lockSensed) && !manualTrigger |=> hoState_reg != HO_WAIT_REF;
    endproperty
    a_no_rearm: assert property (p_no_rearm) else $error("Holdover re-entered before relock.");
    property p_lock_disable;
        lockDisable ##1 lockDisable |-> !lockFlag_reg;
    endproperty
    a_lock_disable: assert property (p_lock_disable) else $error("Lock flag set while disabled.");
    property p_unlock_drop;
        pfdCycle && pfdOverUnlock |=> !lockFlag_reg;
    endproperty
    a_unlock_drop: assert property (p_unlock_drop) else $error("Lock flag survived unlock cycle.");

endmodule
